// ===== dv/stcer_drv_model.sv
// Stepper driver model that reports status flags
`timescale 1ns/1ns
`default_nettype none
module stcer_drv_model (
  // Clock and commanded flags
  input wire logic clk,
  input wire logic [7:0] flags_cmd,
  // Flags toward the bank
  output logic [7:0] driver_status
);
  // Status lags one clock, as a real link would
  always_ff @(posedge clk) begin
    driver_status <= flags_cmd;
  end
endmodule : stcer_drv_model
`default_nettype wire

// ===== dv/stcer_regs_assertions.sv
// Port checker for the stcer register bank
`timescale 1ns/1ns
`default_nettype none
module stcer_regs_assertions (
  // Clock, reset and access
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // Sources and outputs
  input wire logic [31:0] event_set,
  input wire logic [7:0] driver_status,
  input wire logic [3:0] microstep_resolution,
  input wire logic [8:0] microsteps_per_fs,
  input wire logic [11:0] fullsteps_per_revolution,
  input wire logic [7:0] driver_flag_select,
  input wire logic [31:0] events
);
  logic st_wr;
  logic ev_rd;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Access decodes
  assign st_wr = reg_wr && reg_addr == 8'h0A;
  assign ev_rd = reg_rd && reg_addr == 8'h0E;
  // Field, event and readback relations
  a_mres_decode: assert property (microsteps_per_fs ==
    (microstep_resolution > 4'h8 ? 9'h001 : 9'h100 >> microstep_resolution))
    else $error("microstep decode wrong");
  a_mres_write: assert property (st_wr |=>
    microstep_resolution == $past(reg_wdata[3:0])) else $error("mres bad");
  a_fsrev_write: assert property (st_wr |=>
    fullsteps_per_revolution == $past(reg_wdata[15:4])) else $error("fsr bad");
  a_fsrev_hold: assert property (!st_wr |=>
    $stable(fullsteps_per_revolution)) else $error("fsr changed");
  a_motor_event: assert property (|(driver_status & driver_flag_select)
    |=> events[30]) else $error("motor event missing");
  a_event_sticky: assert property (|event_set |=>
    (events & $past(event_set)) == $past(event_set)) else $error("ev lost");
  a_event_read: assert property (ev_rd |=>
    reg_rdata == $past(events)) else $error("event read wrong");
  a_top_zero: assert property (reg_rd && reg_addr == 8'h0A |=>
    reg_rdata[31:24] == 8'h00) else $error("top byte not zero");
endmodule : stcer_regs_assertions
`default_nettype wire

// ===== dv/stcer_regs_bench.sv
// Bench for the stcer register bank
`timescale 1ns/1ns
`default_nettype none
module stcer_regs_bench;
  logic clk, resetn, reg_wr, reg_rd, interrupt_out_pin;
  logic [7:0] reg_addr, flags_cmd, driver_status, dgram_status;
  logic [31:0] reg_wdata, reg_rdata, event_set, events;
  logic [3:0] microstep_resolution;
  logic [8:0] microsteps_per_fs;
  logic [11:0] fullsteps_per_revolution;
  logic [7:0] driver_flag_select;
  int n_errors = 0;
  int checked = 0;
  stcer_regs i_stcer_regs (.*);
  stcer_drv_model i_stcer_drv_model (.*);
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  task step;
    @(posedge clk);
    #2;
  endtask : step
  task chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    step;
    reg_wr = 1'h0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr = a;
    reg_rd = 1'h1;
    step;
    reg_rd = 1'h0;
    chk("rdata", reg_rdata, e);
  endtask : rd
  task finish_test;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  initial begin
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    event_set = '0;
    flags_cmd = '0;
    repeat (8) step;
    resetn = 1'h1;
    rd(8'h0A, 32'h00FB0C80);
    rd(8'h0B, 32'h82029805);
    rd(8'h0C, 32'h0);
    rd(8'h0D, 32'h0);
    wr(8'h0A, 32'h00123456);
    rd(8'h0A, 32'h00123456);
    chk("fsrev", fullsteps_per_revolution, 32'h345);
    chk("mres_raw", microstep_resolution, 32'h6);
    chk("dsel", driver_flag_select, 32'h12);
    for (int c = 0; c < 10; c++) begin
      wr(8'h0A, 32'(c));
      chk("mres", microsteps_per_fs, c > 8 ? 32'h1 : 32'h100 >> c);
    end
    $display("test setup done");
    for (int i = 0; i < 8; i++) begin
      wr(8'h0A, 32'h10000 << i);
      flags_cmd = ~(8'h01 << i);
      step;
      reg_addr = 8'h0E;
      reg_rd = 1'h1;
      step;
      reg_rd = 1'h0;
      step;
      chk("ev", events, 32'h0);
      flags_cmd = 8'h01 << i;
      repeat (2) step;
      chk("ev", events, 32'h40000000);
    end
    flags_cmd = 8'h00;
    step;
    rd(8'h0E, 32'h40000000);
    rd(8'h0E, 32'h0);
    $display("test motor done");
    wr(8'h0C, 32'h1);
    wr(8'h0D, 32'h2);
    event_set = 32'h3;
    step;
    event_set = 32'h0;
    chk("dgram", dgram_status, 32'h01);
    chk("irq", interrupt_out_pin, 32'h1);
    wr(8'h0E, 32'hFFFFFFFF);
    rd(8'h0E, 32'h3);
    rd(8'h0E, 32'h1);
    chk("irq", interrupt_out_pin, 32'h0);
    $display("test routing done");
    finish_test();
  end
endmodule : stcer_regs_bench
bind stcer_regs stcer_regs_assertions i_stcer_regs_assertions (.*);
`default_nettype wire

// ===== hw/stcer_mres_decode.sv
// Microstep resolution decoder
`timescale 1ns/1ns
`default_nettype none
module stcer_mres_decode (
  // Resolution code
  input wire logic [3:0] mres_code,
  // Decoded count and legality
  output logic [8:0] microsteps_per_fs,
  output logic mres_legal
);
  // resolution decode: codes above 8 saturate at full steps
  always_comb begin
    mres_legal = (mres_code <= stcer_pkg::MRES_MAX);
    if (mres_legal) begin
      microsteps_per_fs = 9'(9'h100 >> mres_code);
    end else begin
      microsteps_per_fs = 9'h001;
    end
  end
endmodule : stcer_mres_decode
`default_nettype wire

// ===== hw/stcer_pkg.sv
// Constants for the stepping configuration and event routing register bank
// How it works
// - The 4-bit microstep resolution decodes 0 as 256 microsteps per fullstep, halving per step up to 8 for full steps.
// - A 12-bit fullsteps-per-revolution count sits in bits 15:4 of stepping setup and resets to 200.
// - A driver flag that is both selected and reported set raises the motor driver event at event bit 30.
// - Each of the eight select bits matches one driver status bit, and the selected flags are ORed together.
// - Event flags selected by the datagram status select register feed the eight datagram status bits, low eight only.
// - Reading the event register clears every flag whose read-protect bit is zero and keeps the protected ones.
// - The interrupt output is high whenever any event flag enabled in the interrupt mask is set.
package stcer_pkg;
  localparam logic [7:0] ADDR_STEPPING_SETUP = 8'h0A;
  localparam logic [7:0] ADDR_DGRAM_STATUS_SEL = 8'h0B;
  localparam logic [7:0] ADDR_EVENT_READ_PROTECT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_EVENT_MASK = 8'h0D;
  localparam logic [7:0] ADDR_EVENTS = 8'h0E;
  localparam logic [31:0] RST_STEPPING_SETUP = 32'h00FB0C80;
  localparam logic [31:0] RST_DGRAM_STATUS_SEL = 32'h82029805;
  localparam logic [31:0] RST_EVENT_READ_PROTECT = 32'h00000000;
  localparam logic [31:0] RST_IRQ_EVENT_MASK = 32'h00000000;
  // Field positions inside stepping setup
  localparam int MRES_LSB = 0;
  localparam int MRES_W = 4;
  localparam int FSREV_LSB = 4;
  localparam int FSREV_W = 12;
  localparam int DSEL_LSB = 16;
  localparam int DSEL_W = 8;
  localparam logic [31:0] STEPPING_SETUP_WMASK = 32'h00FFFFFF;
  localparam int MOTOR_EV_BIT = 30;
  localparam int DGRAM_STATUS_W = 8;
  localparam logic [3:0] MRES_MAX = 4'h8;
  localparam logic [3:0] MRES_FINEST_LOG2 = 4'h8;
endpackage : stcer_pkg

// ===== hw/stcer_regs.sv
// Stepping configuration and event routing register bank
`timescale 1ns/1ns
`default_nettype none
module stcer_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register access from the SPI front end
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Event sources, one-cycle pulses per bit
  input wire logic [31:0] event_set,
  // Driver status flags from the stepper driver
  input wire logic [7:0] driver_status,
  // Outputs to the rest of the controller
  output logic [3:0] microstep_resolution,
  output logic [8:0] microsteps_per_fs,
  output logic [11:0] fullsteps_per_revolution,
  output logic [7:0] driver_flag_select,
  output logic [31:0] events,
  output logic [7:0] dgram_status,
  output logic interrupt_out_pin
);
  //////////////////////////////////////////////////////////////////////////
  logic [31:0] step_reg, step_next;
  logic [31:0] dsel_reg, dsel_next;
  logic [31:0] prot_reg, prot_next;
  logic [31:0] mask_reg, mask_next;
  logic [31:0] ev_reg, ev_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] dstat_reg, dstat_next;
  logic irq_reg, irq_next;
  logic motor_ev;
  logic ev_read;

  //////////////////////////////////////////////////////////////////////////
  // Layout limits; every field must sit below the reserved top byte
  localparam int MRES_TOP = stcer_pkg::MRES_LSB + stcer_pkg::MRES_W;
  localparam int FSREV_TOP = stcer_pkg::FSREV_LSB + stcer_pkg::FSREV_W;
  localparam int DSEL_TOP = stcer_pkg::DSEL_LSB + stcer_pkg::DSEL_W;

  // Elaboration checks on the package layout
  if (stcer_pkg::MRES_W != 4) begin : g_bad_mres_w
    $error("resolution field must be four bits wide for the decoder");
  end
  if (MRES_TOP > stcer_pkg::FSREV_LSB) begin : g_bad_mres
    $error("resolution field overlaps the fullsteps field");
  end
  if (FSREV_TOP > stcer_pkg::DSEL_LSB) begin : g_bad_fsrev
    $error("fullsteps field overlaps the driver flag select field");
  end
  if (DSEL_TOP > 24) begin : g_bad_dsel
    $error("driver flag select field overlaps the reserved byte");
  end
  if (stcer_pkg::MOTOR_EV_BIT > 31) begin : g_bad_motor_bit
    $error("motor event bit lies outside the event word");
  end
  if (stcer_pkg::DGRAM_STATUS_W != 8) begin : g_bad_dgram_w
    $error("datagram status width must match the eight status bits");
  end

  //////////////////////////////////////////////////////////////////////////
  // Field helpers; the same fields are sliced in more than one place,
  // so the positions live in one spot
  function automatic logic [3:0] mres_field(input logic [31:0] word);
    mres_field = word[stcer_pkg::MRES_LSB +: stcer_pkg::MRES_W];
  endfunction : mres_field

  function automatic logic [11:0] fsrev_field(input logic [31:0] word);
    fsrev_field = word[stcer_pkg::FSREV_LSB +: stcer_pkg::FSREV_W];
  endfunction : fsrev_field

  function automatic logic [7:0] dsel_field(input logic [31:0] word);
    dsel_field = word[stcer_pkg::DSEL_LSB +: stcer_pkg::DSEL_W];
  endfunction : dsel_field

  // Any flag both active and selected; the driver event and the interrupt
  // share this AND then OR shape
  function automatic logic any_selected(input logic [31:0] flags,
                                        input logic [31:0] sel);
    any_selected = |(flags & sel);
  endfunction : any_selected

  // Read multiplexer; unmapped indexes read as zero so a stray read
  // never shows stale data from another register
  function automatic logic [31:0] read_mux(input logic [7:0] addr,
                                           input logic [31:0] step_w,
                                           input logic [31:0] dsel_w,
                                           input logic [31:0] prot_w,
                                           input logic [31:0] mask_w,
                                           input logic [31:0] ev_w);
    unique case (addr)
      stcer_pkg::ADDR_STEPPING_SETUP: read_mux = step_w;
      stcer_pkg::ADDR_DGRAM_STATUS_SEL: read_mux = dsel_w;
      stcer_pkg::ADDR_EVENT_READ_PROTECT: read_mux = prot_w;
      stcer_pkg::ADDR_IRQ_EVENT_MASK: read_mux = mask_w;
      stcer_pkg::ADDR_EVENTS: read_mux = ev_w;
      default: read_mux = 32'h00000000;
    endcase
  endfunction : read_mux

  //////////////////////////////////////////////////////////////////////////
  // Selected driver flags
  // selected flag OR
  assign motor_ev = any_selected(32'(driver_status),
                                 32'(dsel_field(step_reg)));
  assign ev_read = reg_rd && (reg_addr == stcer_pkg::ADDR_EVENTS);

  // Configuration writes
  always_comb begin
    step_next = step_reg;
    dsel_next = dsel_reg;
    prot_next = prot_reg;
    mask_next = mask_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        stcer_pkg::ADDR_STEPPING_SETUP: begin
          step_next = reg_wdata & stcer_pkg::STEPPING_SETUP_WMASK;
        end
        stcer_pkg::ADDR_DGRAM_STATUS_SEL: dsel_next = reg_wdata;
        stcer_pkg::ADDR_EVENT_READ_PROTECT: prot_next = reg_wdata;
        stcer_pkg::ADDR_IRQ_EVENT_MASK: mask_next = reg_wdata;
        default: ;
      endcase
    end
  end

  // Event flags; a new event beats the read clear in the same cycle
  always_comb begin
    ev_next = ev_reg;
    if (ev_read) begin
      ev_next = ev_reg & prot_reg;
    end
    ev_next = ev_next | event_set;
    if (motor_ev) begin
      ev_next[stcer_pkg::MOTOR_EV_BIT] = 1'b1;
    end
  end

  // Read data, status byte and interrupt, all registered
  always_comb begin
    rdata_next = rdata_reg;
    // Old event value is returned; the clear lands at the same edge
    if (reg_rd) begin
      rdata_next = read_mux(reg_addr, step_reg, dsel_reg, prot_reg,
                            mask_reg, ev_reg);
    end
    dstat_next = ev_next[stcer_pkg::DGRAM_STATUS_W-1:0] &
                 dsel_next[stcer_pkg::DGRAM_STATUS_W-1:0];
    irq_next = any_selected(ev_next, mask_next);
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      step_reg <= stcer_pkg::RST_STEPPING_SETUP;
      dsel_reg <= stcer_pkg::RST_DGRAM_STATUS_SEL;
      prot_reg <= stcer_pkg::RST_EVENT_READ_PROTECT;
      mask_reg <= stcer_pkg::RST_IRQ_EVENT_MASK;
      ev_reg <= 32'h00000000;
      rdata_reg <= 32'h00000000;
      dstat_reg <= 8'h00;
      irq_reg <= 1'b0;
    end else begin
      step_reg <= step_next;
      dsel_reg <= dsel_next;
      prot_reg <= prot_next;
      mask_reg <= mask_next;
      ev_reg <= ev_next;
      rdata_reg <= rdata_next;
      dstat_reg <= dstat_next;
      irq_reg <= irq_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // decoded resolution
  stcer_mres_decode u_mres (
    .mres_code(mres_field(step_reg)),
    .microsteps_per_fs(microsteps_per_fs),
    .mres_legal()
  );

  assign fullsteps_per_revolution = fsrev_field(step_reg);
  // Raw code is passed on as well; users decide how to treat codes above 8
  assign microstep_resolution = mres_field(step_reg);
  assign driver_flag_select = dsel_field(step_reg);
  assign events = ev_reg;
  assign reg_rdata = rdata_reg;
  assign dgram_status = dstat_reg;
  assign interrupt_out_pin = irq_reg;
endmodule : stcer_regs
`default_nettype wire
